/* src/cfg_regs_pkg.sv */
package cfg_regs_pkg;

    // ------------------------------------------------------------------
    // Configuration offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] MISC_OFF = 8'h80;
    localparam logic [7:0] DRIVE_LO_OFF = 8'h92;
    localparam logic [7:0] DRIVE_HI_OFF = 8'h93;

    // ------------------------------------------------------------------
    // Reset values and writable bits
    // ------------------------------------------------------------------
    localparam logic [7:0] MISC_RST = 8'h00;
    localparam logic [15:0] DRIVE_RST = 16'hffff;
    localparam logic [7:0] MISC_WMASK = 8'hc6;

    // ------------------------------------------------------------------
    // Field positions of misc_control_two
    // ------------------------------------------------------------------
    localparam int MISC_MUST_ONE_BIT = 7;
    localparam int MISC_BLIT_BIT = 6;
    localparam int MISC_PALETTE_BIT = 2;
    localparam int MISC_PARSER_GATE_BIT = 1;

    // ------------------------------------------------------------------
    // Field positions of memory_drive_strength
    // ------------------------------------------------------------------
    localparam int DRV_ROW0_CS_BIT = 15;
    localparam int DRV_ROW1_CS_BIT = 14;
    localparam int DRV_ROW2_CS_BIT = 13;
    localparam int DRV_ROW3_CS_BIT = 12;
    localparam int DRV_ADDR_A_LSB = 10;
    localparam int DRV_ADDR_B_LSB = 8;
    localparam int DRV_CLOCK_ENABLE_ONE_LSB = 6;
    localparam int DRV_CLOCK_ENABLE_ZERO_LSB = 4;
    localparam int DRV_DATA_LSB = 2;
    localparam int DRV_CMD_LSB = 0;
    localparam logic [1:0] DRV_DATA_BAD = 2'h3;

    // ------------------------------------------------------------------
    // Strength in half units (2 = 1x, 5 = 2.5x, 8 = 4x)
    // ------------------------------------------------------------------
    localparam logic [3:0] STR_1X = 4'h2;
    localparam logic [3:0] STR_1P5X = 4'h3;
    localparam logic [3:0] STR_2X = 4'h4;
    localparam logic [3:0] STR_2P5X = 4'h5;
    localparam logic [3:0] STR_3X = 4'h6;
    localparam logic [3:0] STR_4X = 4'h8;

    localparam int ROWS = 4;

endpackage : cfg_regs_pkg

/* src/drive_strength_decode.sv */
`timescale 1ns/1ps

// Combinational decode of the drive register into per-group strengths
module drive_strength_decode (
    input wire logic [15:0] drive_i,
    output logic [cfg_regs_pkg::ROWS*4-1:0] cs_str_o,
    output logic [3:0] addr_a_str_o,
    output logic [3:0] addr_b_str_o,
    output logic [3:0] clock_enable_one_str_o,
    output logic [3:0] clock_enable_zero_str_o,
    output logic [3:0] data_str_o,
    output logic [3:0] cmd_str_o,
    output logic data_bad_o
);

    // ------------------------------------------------------------------
    // Field tables
    // ------------------------------------------------------------------
    function automatic logic [3:0] quad_str(input logic [1:0] code);
        case (code)
            2'h0: quad_str = cfg_regs_pkg::STR_4X;
            2'h1: quad_str = cfg_regs_pkg::STR_3X;
            2'h2: quad_str = cfg_regs_pkg::STR_2X;
            default: quad_str = cfg_regs_pkg::STR_1X;
        endcase
    endfunction : quad_str

    function automatic logic [3:0] data_str(input logic [1:0] code);
        case (code)
            2'h0: data_str = cfg_regs_pkg::STR_2P5X;
            2'h1: data_str = cfg_regs_pkg::STR_1P5X;
            default: data_str = cfg_regs_pkg::STR_1X;
        endcase
    endfunction : data_str

    function automatic logic [3:0] cs_str(input logic code);
        cs_str = code ? cfg_regs_pkg::STR_2X : cfg_regs_pkg::STR_3X;
    endfunction : cs_str

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    always_comb begin
        cs_str_o[3:0] = cs_str(drive_i[cfg_regs_pkg::DRV_ROW0_CS_BIT]);
        cs_str_o[7:4] = cs_str(drive_i[cfg_regs_pkg::DRV_ROW1_CS_BIT]);
        cs_str_o[11:8] = cs_str(drive_i[cfg_regs_pkg::DRV_ROW2_CS_BIT]);
        cs_str_o[15:12] = cs_str(drive_i[cfg_regs_pkg::DRV_ROW3_CS_BIT]);
        addr_a_str_o = quad_str(drive_i[cfg_regs_pkg::DRV_ADDR_A_LSB +: 2]);
        addr_b_str_o = quad_str(drive_i[cfg_regs_pkg::DRV_ADDR_B_LSB +: 2]);
        clock_enable_one_str_o = quad_str(drive_i[cfg_regs_pkg::DRV_CLOCK_ENABLE_ONE_LSB +: 2]);
        clock_enable_zero_str_o = quad_str(drive_i[cfg_regs_pkg::DRV_CLOCK_ENABLE_ZERO_LSB +: 2]);
        data_str_o = data_str(drive_i[cfg_regs_pkg::DRV_DATA_LSB +: 2]);
        cmd_str_o = quad_str(drive_i[cfg_regs_pkg::DRV_CMD_LSB +: 2]);
        // Code 11 still drives 1x on data pins but is wrong for the masks
        data_bad_o = drive_i[cfg_regs_pkg::DRV_DATA_LSB +: 2]
            == cfg_regs_pkg::DRV_DATA_BAD;
    end

endmodule : drive_strength_decode

/* src/misc_drive_regs.sv */
`timescale 1ns/1ps

module misc_drive_regs (
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    input wire logic [7:0] CFG_ADDR_I,
    input wire logic CFG_WR_I,
    input wire logic CFG_RD_I,
    input wire logic [7:0] CFG_WDATA_I,
    output logic [7:0] CFG_RDATA_O,
    output logic CFG_RVALID_O,
    output logic TEXT_BLIT_EN_O,
    output logic PALETTE_LOAD_EN_O,
    output logic PARSER_CLK_GATE_EN_O,
    output logic MISC_MUST_ONE_SET_O,
    output logic [15:0] CS_STRENGTH_O,
    output logic [3:0] SLOT0_ADDR_STRENGTH_O,
    output logic [3:0] SLOT1_ADDR_STRENGTH_O,
    output logic [3:0] CLOCK_ENABLE_ONE_STRENGTH_O,
    output logic [3:0] CLOCK_ENABLE_ZERO_STRENGTH_O,
    output logic [3:0] DATA_MASK_STRENGTH_O,
    output logic [3:0] CMD_ADDR_STRENGTH_O,
    output logic DATA_MASK_INVALID_O
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    // Stored registers plus the flopped copies of the decoded strengths
    typedef struct packed {
        logic [7:0] misc;
        logic [15:0] drive;
        logic [7:0] rdata;
        logic rvalid;
        logic [15:0] cs_str;
        logic [3:0] addr_a_str;
        logic [3:0] addr_b_str;
        logic [3:0] clock_enable_one_str;
        logic [3:0] clock_enable_zero_str;
        logic [3:0] data_str;
        logic [3:0] cmd_str;
        logic data_bad;
    } state_s;

    state_s state_r;
    state_s state_nxt;

    logic [15:0] cs_dec;
    logic [3:0] addr_a_dec;
    logic [3:0] addr_b_dec;
    logic [3:0] clock_enable_one_dec;
    logic [3:0] clock_enable_zero_dec;
    logic [3:0] data_dec;
    logic [3:0] cmd_dec;
    logic data_bad_dec;
    logic wr_misc;
    logic wr_drive_lo;
    logic wr_drive_hi;

    // ------------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------------
    // One compare per register byte; a write strobe to any other address
    // matches nothing and is dropped without an error
    function automatic logic hit(input logic strobe,
                                 input logic [7:0] addr,
                                 input logic [7:0] offset);
        hit = strobe && (addr == offset);
    endfunction : hit

    // Replaces one byte lane of the drive word. There is no 16-bit
    // write, so software sees a mixed value between the two byte writes
    function automatic logic [15:0] merge_lane(input logic [15:0] cur,
                                               input logic upper,
                                               input logic [7:0] data);
        merge_lane = cur;
        if (upper) begin
            merge_lane[15:8] = data;
        end else begin
            merge_lane[7:0] = data;
        end
    endfunction : merge_lane

    // Write strobes per register byte
    assign wr_misc = hit(CFG_WR_I, CFG_ADDR_I, cfg_regs_pkg::MISC_OFF);
    assign wr_drive_lo = hit(CFG_WR_I, CFG_ADDR_I,
                             cfg_regs_pkg::DRIVE_LO_OFF);
    assign wr_drive_hi = hit(CFG_WR_I, CFG_ADDR_I,
                             cfg_regs_pkg::DRIVE_HI_OFF);

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    function automatic logic [7:0] read_byte(input logic [7:0] addr,
                                             input logic [7:0] misc,
                                             input logic [15:0] drive);
        case (addr)
            cfg_regs_pkg::MISC_OFF: read_byte = misc;
            cfg_regs_pkg::DRIVE_LO_OFF: read_byte = drive[7:0];
            cfg_regs_pkg::DRIVE_HI_OFF: read_byte = drive[15:8];
            default: read_byte = 8'h00;
        endcase
    endfunction : read_byte

    // ------------------------------------------------------------------
    // Strength decode from the committed drive value
    // ------------------------------------------------------------------
    drive_strength_decode u_decode (
        .drive_i(state_r.drive),
        .cs_str_o(cs_dec),
        .addr_a_str_o(addr_a_dec),
        .addr_b_str_o(addr_b_dec),
        .clock_enable_one_str_o(clock_enable_one_dec),
        .clock_enable_zero_str_o(clock_enable_zero_dec),
        .data_str_o(data_dec),
        .cmd_str_o(cmd_dec),
        .data_bad_o(data_bad_dec)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        // A read taken with a write to the same byte returns the old
        // value; the write still lands at that edge
        state_nxt.rvalid = CFG_RD_I;
        if (CFG_RD_I) begin
            state_nxt.rdata = read_byte(CFG_ADDR_I, state_r.misc,
                                        state_r.drive);
        end
        if (wr_misc) begin
            // Reserved bits never store, so they always read 0
            state_nxt.misc = CFG_WDATA_I
                & cfg_regs_pkg::MISC_WMASK;
        end
        if (wr_drive_lo) begin
            state_nxt.drive = merge_lane(state_r.drive, 1'b0,
                                         CFG_WDATA_I);
        end
        if (wr_drive_hi) begin
            state_nxt.drive = merge_lane(state_r.drive, 1'b1,
                                         CFG_WDATA_I);
        end
        // Output copies lag the register by one cycle so the pad
        // controls see a glitch-free, flopped value
        state_nxt.cs_str = cs_dec;
        state_nxt.addr_a_str = addr_a_dec;
        state_nxt.addr_b_str = addr_b_dec;
        state_nxt.clock_enable_one_str = clock_enable_one_dec;
        state_nxt.clock_enable_zero_str = clock_enable_zero_dec;
        state_nxt.data_str = data_dec;
        state_nxt.cmd_str = cmd_dec;
        state_nxt.data_bad = data_bad_dec;
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            state_r.misc <= cfg_regs_pkg::MISC_RST;
            state_r.drive <= cfg_regs_pkg::DRIVE_RST;
            state_r.rdata <= 8'h00;
            state_r.rvalid <= 1'b0;
            // Copies start at what the decode gives for the drive reset
            // value, so nothing moves when reset is released
            state_r.cs_str <= {cfg_regs_pkg::STR_2X, cfg_regs_pkg::STR_2X,
                               cfg_regs_pkg::STR_2X, cfg_regs_pkg::STR_2X};
            state_r.addr_a_str <= cfg_regs_pkg::STR_1X;
            state_r.addr_b_str <= cfg_regs_pkg::STR_1X;
            state_r.clock_enable_one_str <= cfg_regs_pkg::STR_1X;
            state_r.clock_enable_zero_str <= cfg_regs_pkg::STR_1X;
            state_r.data_str <= cfg_regs_pkg::STR_1X;
            state_r.cmd_str <= cfg_regs_pkg::STR_1X;
            state_r.data_bad <= 1'b1;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign CFG_RDATA_O = state_r.rdata;
    assign CFG_RVALID_O = state_r.rvalid;
    // Enables follow the stored bits; at reset all are off until
    // software does its mandatory setup write
    assign TEXT_BLIT_EN_O =
        state_r.misc[cfg_regs_pkg::MISC_BLIT_BIT];
    assign PALETTE_LOAD_EN_O =
        state_r.misc[cfg_regs_pkg::MISC_PALETTE_BIT];
    assign PARSER_CLK_GATE_EN_O =
        state_r.misc[cfg_regs_pkg::MISC_PARSER_GATE_BIT];
    assign MISC_MUST_ONE_SET_O =
        state_r.misc[cfg_regs_pkg::MISC_MUST_ONE_BIT];
    // Half-unit strength codes, row 0 in the low nibble
    assign CS_STRENGTH_O = state_r.cs_str;
    assign SLOT0_ADDR_STRENGTH_O = state_r.addr_a_str;
    assign SLOT1_ADDR_STRENGTH_O = state_r.addr_b_str;
    assign CLOCK_ENABLE_ONE_STRENGTH_O = state_r.clock_enable_one_str;
    assign CLOCK_ENABLE_ZERO_STRENGTH_O = state_r.clock_enable_zero_str;
    assign DATA_MASK_STRENGTH_O = state_r.data_str;
    assign CMD_ADDR_STRENGTH_O = state_r.cmd_str;
    // The bad mask code is flagged, not blocked: the byte stores as written
    assign DATA_MASK_INVALID_O = state_r.data_bad;

endmodule : misc_drive_regs

/* tb/misc_drive_regs_asserts.sv */
`timescale 1ns/1ps

module misc_drive_regs_asserts (
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    input wire logic [7:0] CFG_ADDR_I,
    input wire logic CFG_WR_I,
    input wire logic CFG_RD_I,
    input wire logic [7:0] CFG_WDATA_I,
    input wire logic [7:0] CFG_RDATA_O,
    input wire logic CFG_RVALID_O,
    input wire logic TEXT_BLIT_EN_O,
    input wire logic PALETTE_LOAD_EN_O,
    input wire logic PARSER_CLK_GATE_EN_O,
    input wire logic [15:0] CS_STRENGTH_O,
    input wire logic DATA_MASK_INVALID_O
);
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);
    // ------------------------------------------------------------------
    // Decoded requests
    // ------------------------------------------------------------------
    logic wr_misc;
    logic wr_lo;
    logic wr_hi;
    logic rd_free;
    assign wr_misc = CFG_WR_I && CFG_ADDR_I == 8'h80;
    assign wr_lo = CFG_WR_I && CFG_ADDR_I == 8'h92;
    assign wr_hi = CFG_WR_I && CFG_ADDR_I == 8'h93;
    assign rd_free = CFG_RD_I && CFG_ADDR_I != 8'h80 &&
        CFG_ADDR_I != 8'h92 && CFG_ADDR_I != 8'h93;
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    // Outputs are checked late enough to be settled in either latency
    a_read_answer: assert property (CFG_RD_I |=> CFG_RVALID_O)
        else $error("read not answered next cycle");
    a_no_stray_valid: assert property (
        !CFG_RD_I |=> !CFG_RVALID_O)
        else $error("read valid without a read");
    a_blit_follow: assert property (wr_misc |-> ##2
        TEXT_BLIT_EN_O == $past(CFG_WDATA_I[6], 2))
        else $error("blit enable does not follow write");
    a_palette_follow: assert property (wr_misc |-> ##2
        PALETTE_LOAD_EN_O == $past(CFG_WDATA_I[2], 2))
        else $error("palette enable does not follow write");
    a_gate_follow: assert property (wr_misc |-> ##2
        PARSER_CLK_GATE_EN_O == $past(CFG_WDATA_I[1], 2))
        else $error("parser gate enable does not follow write");
    a_reserved_zero: assert property (
        CFG_RD_I && CFG_ADDR_I == 8'h80
        |=> CFG_RDATA_O[5:3] == 3'h0 && !CFG_RDATA_O[0])
        else $error("reserved misc bits read nonzero");
    a_row_select: assert property (wr_hi |-> ##3
        CS_STRENGTH_O[11:0] == {($past(CFG_WDATA_I[5], 3) ? 4'h4 : 4'h6),
        ($past(CFG_WDATA_I[6], 3) ? 4'h4 : 4'h6),
        ($past(CFG_WDATA_I[7], 3) ? 4'h4 : 4'h6)})
        else $error("chip select strength wrong");
    a_mask_flag: assert property (wr_lo |-> ##3
        DATA_MASK_INVALID_O == ($past(CFG_WDATA_I[3:2], 3) == 2'h3))
        else $error("data mask flag wrong");
    a_unmapped_zero: assert property (
        rd_free |=> CFG_RDATA_O == 8'h00)
        else $error("unmapped read nonzero");
    c_misc_write: cover property (wr_misc ##2 TEXT_BLIT_EN_O);
    c_mask_valid: cover property (wr_lo ##3 !DATA_MASK_INVALID_O);
    c_unmapped: cover property (rd_free);
endmodule : misc_drive_regs_asserts

/* tb/tb_top.sv */
`timescale 1ns/1ps

module tb_top;
    logic CLK_SYS_I = 1'b0;
    logic RST_I = 1'b1;
    logic [7:0] CFG_ADDR_I = 8'h00;
    logic CFG_WR_I = 1'b0;
    logic CFG_RD_I = 1'b0;
    logic [7:0] CFG_WDATA_I = 8'h00;
    logic [7:0] CFG_RDATA_O;
    logic CFG_RVALID_O, TEXT_BLIT_EN_O, PALETTE_LOAD_EN_O;
    logic PARSER_CLK_GATE_EN_O, MISC_MUST_ONE_SET_O, DATA_MASK_INVALID_O;
    logic [15:0] CS_STRENGTH_O;
    logic [3:0] SLOT0_ADDR_STRENGTH_O, SLOT1_ADDR_STRENGTH_O;
    logic [3:0] CLOCK_ENABLE_ONE_STRENGTH_O, CLOCK_ENABLE_ZERO_STRENGTH_O;
    logic [3:0] DATA_MASK_STRENGTH_O, CMD_ADDR_STRENGTH_O;
    int error_cnt = 0;
    int total_checks = 0;
    int cycles = 0;

    always #20 CLK_SYS_I = ~CLK_SYS_I;

    misc_drive_regs u_misc_drive_regs (.CLK_SYS_I, .RST_I, .CFG_ADDR_I,
        .CFG_WR_I, .CFG_RD_I, .CFG_WDATA_I, .CFG_RDATA_O, .CFG_RVALID_O,
        .TEXT_BLIT_EN_O, .PALETTE_LOAD_EN_O, .PARSER_CLK_GATE_EN_O,
        .MISC_MUST_ONE_SET_O, .CS_STRENGTH_O, .SLOT0_ADDR_STRENGTH_O,
        .SLOT1_ADDR_STRENGTH_O, .CLOCK_ENABLE_ONE_STRENGTH_O, .CLOCK_ENABLE_ZERO_STRENGTH_O,
        .DATA_MASK_STRENGTH_O, .CMD_ADDR_STRENGTH_O, .DATA_MASK_INVALID_O);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: byte %h expected %h", $time, got,
                exp);
        end
    endtask : chk_byte

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: word %h expected %h", $time, got,
                exp);
        end
    endtask : chk_word

    // Strobes are one cycle wide, so each access spans two falling edges
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge CLK_SYS_I);
        CFG_WR_I = 1'b1;
        CFG_ADDR_I = a;
        CFG_WDATA_I = d;
        @(negedge CLK_SYS_I);
        CFG_WR_I = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge CLK_SYS_I);
        CFG_RD_I = 1'b1;
        CFG_ADDR_I = a;
        @(negedge CLK_SYS_I);
        CFG_RD_I = 1'b0;
        chk_byte({7'h00, CFG_RVALID_O}, 8'h01);
        chk_byte(CFG_RDATA_O, exp);
    endtask : rd

    task automatic settle();
        repeat (4) @(negedge CLK_SYS_I);
    endtask : settle

    function automatic logic [7:0] flags();
        return {4'h0, MISC_MUST_ONE_SET_O, TEXT_BLIT_EN_O, PALETTE_LOAD_EN_O,
            PARSER_CLK_GATE_EN_O};
    endfunction : flags

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic test_reset();
        rd(8'h80, 8'h00);
        rd(8'h92, 8'hff);
        rd(8'h93, 8'hff);
        chk_byte(flags(), 8'h00);
        chk_word(CS_STRENGTH_O, 16'h4444);
        chk_word({CLOCK_ENABLE_ONE_STRENGTH_O, CLOCK_ENABLE_ZERO_STRENGTH_O, DATA_MASK_STRENGTH_O,
            CMD_ADDR_STRENGTH_O}, 16'h2222);
        chk_byte({7'h00, DATA_MASK_INVALID_O}, 8'h01);
        $display("test reset done");
    endtask : test_reset

    // Bit 7 is written as 1 in every misc write
    task automatic test_misc();
        wr(8'h80, 8'hff);
        settle();
        rd(8'h80, 8'hc6);
        chk_byte(flags(), 8'h0f);
        wr(8'h80, 8'hb9);
        settle();
        rd(8'h80, 8'h80);
        chk_byte(flags(), 8'h08);
        $display("test misc done");
    endtask : test_misc

    task automatic test_rows();
        wr(8'h93, 8'h00);
        settle();
        chk_word(CS_STRENGTH_O, 16'h6666);
        chk_word({SLOT0_ADDR_STRENGTH_O, SLOT1_ADDR_STRENGTH_O, 8'h00},
            16'h8800);
        wr(8'h93, 8'ha0);
        settle();
        chk_word(CS_STRENGTH_O, 16'h6464);
        rd(8'h93, 8'ha0);
        $display("test rows done");
    endtask : test_rows

    // Every code of the low fields; the mask field uses 10 for 1x
    task automatic test_low();
        logic [3:0] s;
        logic [3:0] m;
        logic [7:0] b;
        for (int c = 0; c < 4; c++) begin
            s = 4'h8 - 4'(2 * c);
            m = (c == 0) ? 4'h5 : (c == 1) ? 4'h3 : 4'h2;
            b = {2'(c), 2'(c), (c == 3) ? 2'h2 : 2'(c), 2'(c)};
            wr(8'h92, b);
            settle();
            chk_word({CLOCK_ENABLE_ONE_STRENGTH_O, CLOCK_ENABLE_ZERO_STRENGTH_O, DATA_MASK_STRENGTH_O,
                CMD_ADDR_STRENGTH_O}, {s, s, m, s});
            chk_byte({7'h00, DATA_MASK_INVALID_O}, 8'h00);
            rd(8'h92, b);
        end
        $display("test low fields done");
    endtask : test_low

    task automatic test_unmapped();
        wr(8'h81, 8'hff);
        rd(8'h81, 8'h00);
        rd(8'h91, 8'h00);
        rd(8'h80, 8'h80);
        $display("test unmapped done");
    endtask : test_unmapped

    // ------------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    // Whole run needs under a hundred cycles
    always @(posedge CLK_SYS_I) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    initial begin
        repeat (5) @(negedge CLK_SYS_I);
        RST_I = 1'b0;
        test_reset();
        test_misc();
        test_rows();
        test_low();
        test_unmapped();
        report_and_stop();
    end
endmodule : tb_top

bind misc_drive_regs misc_drive_regs_asserts u_misc_drive_regs_asserts (
    .CLK_SYS_I, .RST_I, .CFG_ADDR_I, .CFG_WR_I, .CFG_RD_I, .CFG_WDATA_I,
    .CFG_RDATA_O, .CFG_RVALID_O, .TEXT_BLIT_EN_O, .PALETTE_LOAD_EN_O,
    .PARSER_CLK_GATE_EN_O, .CS_STRENGTH_O, .DATA_MASK_INVALID_O);
